// ---- hdl/cfb_consts.vh ----
// constants for the flag, bank and vector datapath block
`ifndef CFB_CONSTS_VH
`define CFB_CONSTS_VH

// ==============================================
// register byte offsets
`define CFB_OFF_CMD     8'h00
`define CFB_OFF_OPND    8'h04
`define CFB_OFF_STAT    8'h08
`define CFB_OFF_FLAG    8'h0C
`define CFB_OFF_RES     8'h10
`define CFB_OFF_PC      8'h14
`define CFB_OFF_VBASE   8'h18
`define CFB_OFF_REG0    8'h40
`define CFB_NUM_VIEW    12

// ==============================================
// reset values
`define CFB_FLAG_RST    8'h00
`define CFB_PC_RST      16'h0000
`define CFB_VBASE_RST   8'h00

// ==============================================
// field positions
`define CFB_CMD_OP      0
`define CFB_CMD_DST     8
`define CFB_CMD_SRC     12
`define CFB_OP_IMM      0
`define CFB_OP_VEC      8
`define CFB_OP_AMT      14
`define CFB_OP_GC       17
`define CFB_OP_BA       19
`define CFB_OP_BB       20
`define CFB_OP_OPT      21
`define CFB_OP_IND      22
`define CFB_OP_USEIMM   23
`define CFB_FN          3
`define CFB_FV          2
`define CFB_FC          1
`define CFB_FZ          0

// ==============================================
// operation codes
`define CFB_ADD         5'h00
`define CFB_ADC         5'h01
`define CFB_SUB         5'h02
`define CFB_SBC         5'h03
`define CFB_CMP         5'h04
`define CFB_CPL         5'h05
`define CFB_AND         5'h06
`define CFB_OR          5'h07
`define CFB_XOR         5'h08
`define CFB_BIT         5'h09
`define CFB_SHL         5'h0A
`define CFB_SHR         5'h0B
`define CFB_ROR         5'h0C
`define CFB_MOVE        5'h0D
`define CFB_SWAP        5'h0E
`define CFB_VCALL       5'h0F
`define CFB_RESUME      5'h10

// ==============================================
// interrupt gate option codes and timing in t-states
`define CFB_GC_KEEP     2'h0
`define CFB_GC_REST     2'h1
`define CFB_GC_SET      2'h2
`define CFB_GC_CLR      2'h3
`define CFB_T_REG       3'h2
`define CFB_T_MEM       3'h3

`endif

// ---- hdl/cfb_alu.v ----
// combinational eight-bit alu with flags
`timescale 1ns/1ps
`include "cfb_consts.vh"

module cfb_alu (
    input  wire [4:0] i_op,
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire [2:0] i_amt,
    input  wire       i_cin,
    output reg  [7:0] o_res,
    output reg  [3:0] o_flags,
    output reg  [3:0] o_mask,
    output reg        o_wr
);

    reg        sub;
    reg  [7:0] bx;
    reg        cix;
    reg  [8:0] sum;
    reg [15:0] wide;
    reg        c;

    // flags are formed beside the result, no extra t-state
    always @* begin
        sub  = (i_op == `CFB_SUB) | (i_op == `CFB_SBC) | (i_op == `CFB_CMP);
        bx   = sub ? ~i_b : i_b;
        cix  = (i_op == `CFB_ADC) ? i_cin :
               (i_op == `CFB_SBC) ? ~i_cin : sub;
        sum  = {1'b0, i_a} + {1'b0, bx} + {8'h00, cix};
        wide = 16'h0000;
        o_res = 8'h00;
        o_mask = 4'h0;
        o_wr = 1'b0;
        c = 1'b0;
        case (i_op)
            `CFB_ADD, `CFB_ADC, `CFB_SUB, `CFB_SBC, `CFB_CMP: begin
                o_res = sum[7:0];
                c = sub ? ~sum[8] : sum[8];
                o_mask = 4'hF;
                o_wr = (i_op != `CFB_CMP);
            end
            `CFB_CPL: begin
                o_res = ~i_a;
                o_mask = 4'h9;
                o_wr = 1'b1;
            end
            `CFB_AND, `CFB_BIT: begin
                o_res = i_a & i_b;
                o_mask = 4'h9;
                o_wr = (i_op == `CFB_AND);
            end
            `CFB_OR: begin
                o_res = i_a | i_b;
                o_mask = 4'h9;
                o_wr = 1'b1;
            end
            `CFB_XOR: begin
                o_res = i_a ^ i_b;
                o_mask = 4'h9;
                o_wr = 1'b1;
            end
            `CFB_SHL: begin
                wide = {8'h00, i_a} << i_amt;
                o_res = wide[7:0];
                c = wide[8];
                o_mask = 4'hB;
                o_wr = 1'b1;
            end
            `CFB_SHR: begin
                wide = {i_a, 8'h00} >> i_amt;
                o_res = wide[15:8];
                c = wide[7];
                o_mask = 4'hB;
                o_wr = 1'b1;
            end
            `CFB_ROR: begin
                wide = {i_a, i_a} >> i_amt;
                o_res = wide[7:0];
                c = (i_amt != 3'h0) & wide[7];
                o_mask = 4'hB;
                o_wr = 1'b1;
            end
            `CFB_MOVE: begin
                o_res = i_b;
                o_wr = 1'b1;
            end
            default: begin
                o_res = 8'h00;
            end
        endcase
        // overflow only from signed add form; logic ops mask it off
        o_flags = {o_res[7], (i_a[7] == bx[7]) & (sum[7] != i_a[7]),
                   c, o_res == 8'h00};
    end

endmodule // cfb_alu

// ---- hdl/cfb_bank.v ----
// four banks of six registers behind a twelve-entry active view
`timescale 1ns/1ps
`include "cfb_consts.vh"

module cfb_bank (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_sel_a,
    input  wire       i_sel_b,
    input  wire [3:0] i_ra,
    input  wire [3:0] i_rb,
    input  wire [3:0] i_rc,
    input  wire       i_we,
    input  wire [3:0] i_wi,
    input  wire [7:0] i_wd,
    output wire [7:0] o_da,
    output wire [7:0] o_db,
    output wire [7:0] o_dc
);

    reg [7:0] mem [0:23];
    integer   k;

    // view index to physical slot; 24 means no register
    function [4:0] phys;
        input [3:0] idx;
        input       sa;
        input       sb;
        begin
            if (idx < 4'h6)
                phys = {1'b0, idx} + (sa ? 5'h06 : 5'h00);
            else if (idx < 4'hC)
                phys = {1'b0, idx} + (sb ? 5'h0C : 5'h06);
            else
                phys = 5'h18;
        end
    endfunction

    wire [4:0] pa = phys(i_ra, i_sel_a, i_sel_b);
    wire [4:0] pb = phys(i_rb, i_sel_a, i_sel_b);
    wire [4:0] pc = phys(i_rc, i_sel_a, i_sel_b);
    wire [4:0] pw = phys(i_wi, i_sel_a, i_sel_b);

    assign o_da = (pa < 5'h18) ? mem[pa] : 8'h00;
    assign o_db = (pb < 5'h18) ? mem[pb] : 8'h00;
    assign o_dc = (pc < 5'h18) ? mem[pc] : 8'h00;

    // only the addressed slot changes; idle banks keep contents
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (k = 0; k < 24; k = k + 1)
                mem[k] <= 8'h00;
        end else if (i_we && pw < 5'h18) begin
            mem[pw] <= i_wd;
        end
    end

endmodule // cfb_bank

// ---- hdl/cfb_top.v ----
// flag, bank and vector datapath with an axi4-lite register slave
`timescale 1ns/1ps
`include "cfb_consts.vh"

module cfb_top #(
    parameter STK_DEPTH = 8,
    parameter STK_AW    = 3
) (
    input  wire        I_MCLK,
    input  wire        I_RST_B,
    input  wire [7:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output wire        O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output wire        O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [7:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output wire        O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    output reg         O_MEM_WE,
    output reg  [15:0] O_MEM_ADDR,
    output reg  [7:0]  O_MEM_DATA,
    output wire        O_IRQ_GATE,
    output wire        O_BUSY
);

    // ==============================================
    // sequencer states, one-hot
    localparam S_IDLE = 2'b01;
    localparam S_RUN  = 2'b10;

    reg  [1:0]  state_q;
    reg  [2:0]  tcnt_q;
    reg  [4:0]  op_q;
    reg  [3:0]  dst_q;
    reg  [3:0]  src_q;
    reg  [23:0] opnd_q;
    reg  [23:0] opnd_reg_q;
    reg  [7:0]  flag_byte_q;
    reg  [15:0] pc_q;
    reg  [7:0]  vector_page_base_q;
    reg  [7:0]  res_q;
    reg         master_irq_gate_q;
    reg         sel_a_q;
    reg         sel_b_q;
    reg  [STK_AW-1:0] sp_q;
    reg  [22:0] stk [0:STK_DEPTH-1];

    // ==============================================
    // byte-lane merge for the wide operand register
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      b;
        begin
            lane_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    lane_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    // gate option decode shared by swap and resume
    function gate_next;
        input [1:0] code;
        input       cur;
        input       saved;
        begin
            case (code)
                `CFB_GC_REST: gate_next = saved;
                `CFB_GC_SET:  gate_next = 1'b1;
                `CFB_GC_CLR:  gate_next = 1'b0;
                default:      gate_next = cur;
            endcase
        end
    endfunction

    // ==============================================
    // axi4-lite write channel
    reg        aw_v_q;
    reg [7:0]  aw_a_q;
    reg        w_v_q;
    reg [31:0] w_d_q;
    reg [3:0]  w_s_q;

    assign O_AWREADY = ~aw_v_q & ~O_BVALID;
    assign O_WREADY  = ~w_v_q & ~O_BVALID;

    wire        aw_hs  = I_AWVALID & O_AWREADY;
    wire        w_hs   = I_WVALID & O_WREADY;
    wire        do_wr  = (aw_v_q | aw_hs) & (w_v_q | w_hs);
    wire [7:0]  wa     = aw_v_q ? aw_a_q : I_AWADDR;
    wire [31:0] wd     = w_v_q ? w_d_q : I_WDATA;
    wire [3:0]  ws     = w_v_q ? w_s_q : I_WSTRB;
    wire        busy   = state_q[1];
    wire        wa_reg = (wa[7:0] >= `CFB_OFF_REG0) & (wa[1:0] == 2'b00)
                         & (wa[7:2] < 6'h10 + `CFB_NUM_VIEW);
    wire        wa_ok  = (wa == `CFB_OFF_CMD) | (wa == `CFB_OFF_OPND)
                         | (wa == `CFB_OFF_FLAG) | (wa == `CFB_OFF_PC)
                         | (wa == `CFB_OFF_VBASE) | (wa == `CFB_OFF_STAT)
                         | (wa == `CFB_OFF_RES) | wa_reg;
    // writes that would race the running operation are dropped
    wire        wr_live = do_wr & ~busy;
    wire        launch  = wr_live & (wa == `CFB_OFF_CMD) & ws[0];
    wire [3:0]  wa_idx  = wa[5:2];

    // address and data may arrive in either order
    always @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_v_q   <= 1'b0;
            aw_a_q   <= 8'h00;
            w_v_q    <= 1'b0;
            w_d_q    <= 32'h0000_0000;
            w_s_q    <= 4'h0;
            O_BVALID <= 1'b0;
            O_BRESP  <= 2'b00;
        end else begin
            if (do_wr) begin
                aw_v_q   <= 1'b0;
                w_v_q    <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP  <= wa_ok ? 2'b00 : 2'b10;
            end else begin
                if (aw_hs) begin
                    aw_v_q <= 1'b1;
                    aw_a_q <= I_AWADDR;
                end
                if (w_hs) begin
                    w_v_q <= 1'b1;
                    w_d_q <= I_WDATA;
                    w_s_q <= I_WSTRB;
                end
                if (O_BVALID & I_BREADY)
                    O_BVALID <= 1'b0;
            end
        end
    end

    // ==============================================
    // register bank and alu
    wire [7:0] dst_val;
    wire [7:0] src_val;
    wire [7:0] bus_val;
    wire [7:0] alu_res;
    wire [3:0] alu_flags;
    wire [3:0] alu_mask;
    wire       alu_wr;
    wire       commit   = busy & (tcnt_q == 3'h1);
    wire       is_shift = (op_q == `CFB_SHL) | (op_q == `CFB_SHR) | (op_q == `CFB_ROR);
    wire       to_mem   = opnd_q[`CFB_OP_IND] & ~is_shift;
    wire [7:0] b_opnd   = opnd_q[`CFB_OP_USEIMM] ? opnd_q[7:0] : src_val;
    wire       reg_we   = commit & alu_wr & ~to_mem;
    wire       bus_we   = wr_live & wa_reg & ws[0];

    cfb_bank u_bank (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_sel_a (sel_a_q),
        .i_sel_b (sel_b_q),
        .i_ra    (dst_q),
        .i_rb    (src_q),
        .i_rc    (I_ARADDR[5:2]),
        .i_we    (reg_we | bus_we),
        .i_wi    (reg_we ? dst_q : wa_idx),
        .i_wd    (reg_we ? alu_res : wd[7:0]),
        .o_da    (dst_val),
        .o_db    (src_val),
        .o_dc    (bus_val)
    );

    cfb_alu u_alu (
        .i_op    (op_q),
        .i_a     (dst_val),
        .i_b     (b_opnd),
        .i_amt   (opnd_q[`CFB_OP_AMT +: 3]),
        .i_cin   (flag_byte_q[`CFB_FC]),
        .o_res   (alu_res),
        .o_flags (alu_flags),
        .o_mask  (alu_mask),
        .o_wr    (alu_wr)
    );

    // ==============================================
    // operation sequencer: one cycle per t-state
    always @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_q <= S_IDLE;
            tcnt_q  <= 3'h0;
            op_q    <= 5'h00;
            dst_q   <= 4'h0;
            src_q   <= 4'h0;
            opnd_q  <= 24'h00_0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        state_q <= S_RUN;
                        op_q    <= wd[`CFB_CMD_OP +: 5];
                        dst_q   <= wd[`CFB_CMD_DST +: 4];
                        src_q   <= wd[`CFB_CMD_SRC +: 4];
                        opnd_q  <= opnd_reg_q;
                        // memory destination costs one more t-state
                        tcnt_q  <= (opnd_reg_q[`CFB_OP_IND]
                                    && (wd[`CFB_CMD_OP +: 5] < `CFB_SHL
                                        || wd[`CFB_CMD_OP +: 5] == `CFB_MOVE))
                                   ? `CFB_T_MEM : `CFB_T_REG;
                    end
                end
                S_RUN: begin
                    tcnt_q <= tcnt_q - 3'h1;
                    if (commit)
                        state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ==============================================
    // architectural state update from bus register writes and at the last t-state
    wire [22:0] top_ent = stk[sp_q - {{(STK_AW-1){1'b0}}, 1'b1}];
    wire        is_alu  = (op_q < `CFB_SWAP);
    wire [31:0] opnd_mrg = lane_merge({8'h00, opnd_reg_q}, wd, ws);

    always @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            flag_byte_q        <= `CFB_FLAG_RST;
            pc_q               <= `CFB_PC_RST;
            vector_page_base_q <= `CFB_VBASE_RST;
            master_irq_gate_q  <= 1'b0;
            sel_a_q            <= 1'b0;
            sel_b_q            <= 1'b0;
            sp_q               <= {STK_AW{1'b0}};
            res_q              <= 8'h00;
            opnd_reg_q         <= 24'h00_0000;
            O_MEM_WE           <= 1'b0;
            O_MEM_ADDR         <= 16'h0000;
            O_MEM_DATA         <= 8'h00;
        end else begin
            O_MEM_WE <= 1'b0;
            if (do_wr && wa == `CFB_OFF_OPND)
                opnd_reg_q <= opnd_mrg[23:0];
            if (wr_live && wa == `CFB_OFF_FLAG && ws[0])
                flag_byte_q <= wd[7:0];
            if (wr_live && wa == `CFB_OFF_PC)
                pc_q <= {ws[1] ? wd[15:8] : pc_q[15:8], ws[0] ? wd[7:0] : pc_q[7:0]};
            if (wr_live && wa == `CFB_OFF_VBASE && ws[0])
                vector_page_base_q <= wd[7:0];
            if (commit && is_alu) begin
                // masked merge keeps flags the op leaves alone
                flag_byte_q[3:0] <= (alu_flags & alu_mask)
                                    | (flag_byte_q[3:0] & ~alu_mask);
                if (alu_wr)
                    res_q <= alu_res;
                if (alu_wr && to_mem) begin
                    O_MEM_WE   <= 1'b1;
                    O_MEM_ADDR <= {8'h00, dst_val};
                    O_MEM_DATA <= alu_res;
                end
            end
            if (commit && op_q == `CFB_SWAP) begin
                sel_a_q <= opnd_q[`CFB_OP_BA];
                sel_b_q <= opnd_q[`CFB_OP_BB];
                // reserved code 1 leaves the gate alone
                if (opnd_q[`CFB_OP_GC +: 2] != `CFB_GC_REST)
                    master_irq_gate_q <= gate_next(opnd_q[`CFB_OP_GC +: 2],
                                                   master_irq_gate_q,
                                                   master_irq_gate_q);
            end
            if (commit && op_q == `CFB_VCALL) begin
                // stack is circular; a push past depth overwrites the oldest
                sp_q <= sp_q + {{(STK_AW-1){1'b0}}, 1'b1};
                pc_q <= {vector_page_base_q, 2'b00, opnd_q[`CFB_OP_VEC +: 6]};
                if (opnd_q[`CFB_OP_OPT])
                    master_irq_gate_q <= 1'b0;
            end
            if (commit && op_q == `CFB_RESUME) begin
                sp_q <= sp_q - {{(STK_AW-1){1'b0}}, 1'b1};
                pc_q <= top_ent[22:7];
                master_irq_gate_q <= gate_next(opnd_q[`CFB_OP_GC +: 2],
                                               master_irq_gate_q, top_ent[6]);
                if (opnd_q[`CFB_OP_OPT]) begin
                    flag_byte_q[3:0] <= top_ent[5:2];
                    sel_a_q          <= top_ent[1];
                    sel_b_q          <= top_ent[0];
                end
            end
        end
    end

    // stack store: pc, gate, flags, bank selection
    always @(posedge I_MCLK) begin
        if (commit && op_q == `CFB_VCALL)
            stk[sp_q] <= {pc_q, master_irq_gate_q, flag_byte_q[3:0],
                          sel_a_q, sel_b_q};
    end

    // ==============================================
    // axi4-lite read channel, answer one cycle after address
    reg [31:0] rd_d;
    reg        rd_ok;
    wire       ra_reg = (I_ARADDR >= `CFB_OFF_REG0) & (I_ARADDR[1:0] == 2'b00)
                        & (I_ARADDR[7:2] < 6'h10 + `CFB_NUM_VIEW);

    assign O_ARREADY = ~O_RVALID;

    // read decode, unmapped reads answer zero with error
    always @* begin
        rd_d  = 32'h0000_0000;
        rd_ok = 1'b1;
        case (I_ARADDR)
            `CFB_OFF_CMD:   rd_d = {16'h0, src_q, dst_q, 3'h0, op_q};
            `CFB_OFF_OPND:  rd_d = {8'h00, opnd_reg_q};
            `CFB_OFF_STAT:  rd_d = {24'h0, 1'b0, sp_q, sel_b_q, sel_a_q,
                                    master_irq_gate_q, busy};
            `CFB_OFF_FLAG:  rd_d = {24'h0, flag_byte_q};
            `CFB_OFF_RES:   rd_d = {24'h0, res_q};
            `CFB_OFF_PC:    rd_d = {16'h0, pc_q};
            `CFB_OFF_VBASE: rd_d = {24'h0, vector_page_base_q};
            default: begin
                if (ra_reg)
                    rd_d = {24'h0, bus_val};
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0000_0000;
            O_RRESP  <= 2'b00;
        end else if (I_ARVALID && O_ARREADY) begin
            O_RVALID <= 1'b1;
            O_RDATA  <= rd_d;
            O_RRESP  <= rd_ok ? 2'b00 : 2'b10;
        end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
        end
    end

    assign O_IRQ_GATE = master_irq_gate_q;
    assign O_BUSY     = busy;

endmodule // cfb_top

// ---- tb/cfb_assertions.sv ----
// checker of bus handshakes and operation timing at the top ports
`timescale 1ns/1ps
// ====================
// port checker
module cfb_chk (
    input wire I_MCLK,
    input wire I_RST_B,
    input wire O_AWREADY,
    input wire O_WREADY,
    input wire O_BVALID,
    input wire I_BREADY,
    input wire [1:0] O_BRESP,
    input wire O_ARREADY,
    input wire O_RVALID,
    input wire I_RREADY,
    input wire [31:0] O_RDATA,
    input wire O_MEM_WE,
    input wire O_BUSY
);
    // one clock domain, so clock and reset are shared
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    a_wr_block: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write accepted during response");
    a_rd_block: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read accepted during response");
    a_b_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response not released");
    a_r_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read response not released");
    a_busy_len: assert property ($rose(O_BUSY) |-> O_BUSY[*2] ##[1:2] !O_BUSY)
        else $error("operation length wrong");
    a_mem_pulse: assert property (O_MEM_WE |-> $past(O_BUSY) && !O_BUSY ##1 !O_MEM_WE)
        else $error("memory write pulse wrong");
endmodule // cfb_chk

bind cfb_top cfb_chk u_chk (.*);

// ---- tb/cfb_top_tb_top.sv ----
// self-checking bench for the flag, bank and vector datapath
`timescale 1ns/1ps
module cfb_top_tb_top;
    reg c = 0, rst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, gt;
    reg [7:0] awa = 0, ara = 0, a, b, f, mdd;
    reg [31:0] wd = 0, d;
    reg [15:0] mad;
    reg [12:0] e;
    reg [4:0] o;
    reg [2:0] s;
    reg [1:0] g, br, rr;
    wire awr, wrd, bv, arr, rv, mwe, gate;
    wire [31:0] rdat;
    wire [15:0] ma;
    wire [7:0] md;
    int error_cnt = 0, checks_done = 0, n, k;
    // ====================
    // clock, design and memory write capture
    always #5 c = ~c;
    cfb_top dut (.I_MCLK(c), .I_RST_B(rst), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(br),
        .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rry), .O_MEM_WE(mwe),
        .O_MEM_ADDR(ma), .O_MEM_DATA(md), .O_IRQ_GATE(gate), .O_BUSY());
    always @(posedge c) if (mwe === 1'b1) begin
        mad <= ma;
        mdd <= md;
    end
    // ====================
    // report, compare and bus tasks
    task print_verdict;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [31:0] q, x);
        checks_done++;
        if (q !== x) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, q, x);
        end
    endtask
    // a hung handshake counts as a mismatch
    task tmo;
        n++;
        if (n > 60) begin
            error_cnt++;
            print_verdict;
        end
    endtask
    // ready sampled at the falling edge, so it is settled for the next rise
    task wr(input [7:0] ad, input [31:0] v, input [1:0] x = 0);
        reg ta, tw, tb;
        n = 0;
        @(posedge c);
        {awa, wd, awv, wv, bry} <= {ad, v, 3'h7};
        do begin
            @(negedge c);
            {ta, tw, tb, g} = {awr & awv, wrd & wv, bv, br};
            @(posedge c);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            tmo;
        end while (!tb);
        bry <= 0;
        chk(g, x);
    endtask
    task rd(input [7:0] ad, input [1:0] x = 0);
        reg ta, tr;
        n = 0;
        @(posedge c);
        {ara, arv, rry} <= {ad, 2'h3};
        do begin
            @(negedge c);
            {ta, tr, d, g} = {arr & arv, rv, rdat, rr};
            @(posedge c);
            if (ta) arv <= 0;
            tmo;
        end while (!tr);
        rry <= 0;
        chk(g, x);
    endtask
    // launch and poll busy, bounded
    task op(input [31:0] cm, pd);
        wr(8'h04, pd);
        wr(8'h00, cm);
        k = 0;
        do begin
            rd(8'h08);
            k++;
        end while (d[0] !== 1'b0 && k < 9);
        chk(d[0], 0);
    endtask
    // reference alu: {write, n, v, c, z, result}
    function [12:0] mdl(input [4:0] p, input [7:0] x, y, input [2:0] h, input [3:0] fl);
        reg [8:0] t;
        reg [7:0] r;
        reg w;
        {w, r} = {1'b1, x};
        case (p)
            0, 1: begin t = x + y + (p == 1 & fl[1]); r = t; fl[1] = t[8];
                fl[2] = x[7] == y[7] && r[7] != x[7]; end
            2, 3, 4: begin t = x - y - (p == 3 & fl[1]); r = t; fl[1] = t[8];
                fl[2] = x[7] != y[7] && r[7] != x[7]; w = p != 4; end
            5: r = ~x;
            6: r = x & y;
            7: r = x | y;
            8: r = x ^ y;
            9: begin r = x & y; w = 0; end
            10: begin r = x << h; fl[1] = h ? x[8 - h] : 0; end
            11: begin r = x >> h; fl[1] = h ? x[h - 1] : 0; end
            13: r = y;
            default: begin r = (x >> h) | (x << (8 - h)); fl[1] = h ? x[h - 1] : 0; end
        endcase
        mdl = {w, p == 13 ? fl : {r[7], fl[2:1], r == 0}, r};
    endfunction
    // ====================
    // main sequence
    initial begin
        void'($urandom(8));
        repeat (3) @(posedge c);
        rst <= 1;
        rd(8'h0C); chk(d, 0);
        rd(8'h3C, 2); chk(d, 0);
        wr(8'h3C, 1, 2);
        $display("test reset done");
        for (int i = 0; i < 52; i++) begin
            {o, a, b, f, s} = {5'(i % 14), 8'($urandom), 8'($urandom), 8'($urandom), 3'($urandom)};
            wr(8'h40, a); wr(8'h44, b ^ {8{i[0]}}); wr(8'h0C, f);
            op(32'h1000 | o, s << 14 | i[0] << 23 | b);
            e = mdl(o, a, b, s, f[3:0]);
            rd(8'h40); chk(d, e[12] ? e[7:0] : a);
            rd(8'h0C); chk(d, {f[7:4], e[11:8]});
        end
        $display("test alu done");
        wr(8'h40, 8'hAA); op(32'h0E, 32'h80000); rd(8'h40); chk(d, 0);
        wr(8'h40, 8'h55); op(32'h0E, 0); rd(8'h40); chk(d, 8'hAA);
        wr(8'h58, 8'h77); op(32'h0E, 32'h100000); rd(8'h58); chk(d, 0);
        op(32'h0E, 0); rd(8'h58); chk(d, 8'h77);
        gt = 0;
        for (int j = 0; j < 4; j++) begin
            g = 8'hD2 >> (2 * j);
            gt = g == 2 ? 1 : g == 3 ? 0 : gt;
            op(32'h0E, g << 17);
            rd(8'h08); chk(d, gt << 1); chk(gate, gt);
        end
        $display("test swap done");
        f = $urandom;
        wr(8'h18, f); wr(8'h0C, 5); op(32'h0E, 32'h40000);
        op(32'h0F, 32'h203F00);
        rd(8'h14); chk(d, {f, 8'h3F});
        rd(8'h08); chk(d, 8'h10);
        wr(8'h0C, 8'h0A); op(32'h0E, 32'h80000);
        op(32'h10, 32'h220000);
        rd(8'h0C); chk(d, 5);
        rd(8'h08); chk(d, 2);
        rd(8'h14); chk(d, 0);
        $display("test call done");
        wr(8'h40, 8'h33); wr(8'h44, 8'h10); op(32'h1000, 32'h400000);
        chk(mad, 16'h33); chk(mdd, 8'h43);
        rd(8'h10); chk(d, 8'h43);
        $display("test indirect done");
        print_verdict;
    end
endmodule // cfb_top_tb_top
